// File: include/tcc_pkg.sv
// constants and types for the timer channel capture/compare block
// Operation
// - value holds capture or compare, reset zero
// - capture read freezes both bytes until other
// - control write releases the read buffer
// - compare bytes buffered, moved together when both
// - control write discards half-done compare write
// - capture edge sets event flag bit 7
// - counter match sets flag in compare/pwm
// - interrupt request when flag and enable
// - clear flag by read then write zero
// - event between read and write restarts clear
// - reset clears flag, writing one ignored
// - bit 6 interrupt enable, reset zero
// - mode select b gives edge-aligned pwm
// - mode select a picks capture or compare
// - edge/level 00 releases the pin
// - capture edge select rising, falling, both
// - compare pin action none, toggle, low, high
// - pwm polarity high-true or low-true pulses
// - center-aligned select overrides channel modes
package tcc_pkg;

    // ****************************************************************
    // register map: register index, byte address is four times it
    // ****************************************************************
    localparam logic [7:0]  TCC_IDX_SC      = 8'h16;
    localparam logic [7:0]  TCC_IDX_VAL_HI  = 8'h17;
    localparam logic [7:0]  TCC_IDX_VAL_LO  = 8'h18;
    localparam logic [9:0]  TCC_ADDR_SC     = {TCC_IDX_SC, 2'b00};
    localparam logic [9:0]  TCC_ADDR_VAL_HI = {TCC_IDX_VAL_HI, 2'b00};
    localparam logic [9:0]  TCC_ADDR_VAL_LO = {TCC_IDX_VAL_LO, 2'b00};
    localparam int          TCC_ADDR_W      = 10;

    // ****************************************************************
    // control register fields and reset values
    // ****************************************************************
    localparam int          TCC_BIT_FLAG    = 7;
    localparam int          TCC_BIT_IE      = 6;
    localparam int          TCC_BIT_MSB     = 5;
    localparam int          TCC_BIT_MSA     = 4;
    localparam int          TCC_BIT_ELS_HI  = 3;
    localparam int          TCC_BIT_ELS_LO  = 2;
    localparam logic [1:0]  TCC_ELS_OFF     = 2'h0;
    localparam logic [1:0]  TCC_ELS_TOGGLE  = 2'h1;
    localparam logic [1:0]  TCC_ELS_CLEAR   = 2'h2;
    localparam logic [1:0]  TCC_ELS_SET     = 2'h3;
    localparam logic [15:0] TCC_VAL_RST     = 16'h0000;
    localparam logic [15:0] TCC_CNT_ZERO    = 16'h0000;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic       chan_event_flag;
        logic       chan_irq_enable;
        logic       mode_sel_b;
        logic       mode_sel_a;
        logic [1:0] edge_level_sel;
    } tcc_ctrl_t;

    localparam tcc_ctrl_t TCC_CTRL_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 2'h0};

    typedef enum logic [1:0] {
        TCC_MODE_CAPTURE,
        TCC_MODE_COMPARE,
        TCC_MODE_EDGE_PWM,
        TCC_MODE_CENTER_PWM
    } tcc_mode_t;

    typedef struct packed {
        logic [15:0] main_counter;
        logic        count_tick;
        logic        count_up;
        logic        center_aligned_sel;
    } tcc_counter_t;

endpackage

// File: hdl/tcc_channel.sv
// one timer channel with capture, compare and pwm, on an ahb-lite slave
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module tcc_channel (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire tcc_pkg::tcc_counter_t cnt,
    input  wire logic                  pin_in,
    output logic                       pin_out,
    output logic                       pin_oe,
    output logic                       chan_irq
);
    import tcc_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    tcc_ctrl_t                ctrl_q;
    logic [15:0]              value_q;
    logic [15:0]              rbuf_q;
    logic                     rlatched_q;
    logic                     rlatch_hi_q;
    logic [7:0]               whold_hi_q;
    logic [7:0]               whold_lo_q;
    logic                     wgot_hi_q;
    logic                     wgot_lo_q;
    logic                     clr_armed_q;
    logic                     pin_s1_q;
    logic                     pin_s2_q;
    logic                     pin_prev_q;
    logic [2:0]               pin_fill_q;
    logic                     pin_out_q;
    logic                     dp_wr_q;
    logic [TCC_ADDR_W-1:0]    dp_addr_q;
    logic [31:0]              hrdata_q;
    logic                     irq_q;

    // ****************************************************************
    // mode decode
    // ****************************************************************
    tcc_mode_t                mode;
    wire logic [1:0]          els = ctrl_q.edge_level_sel;
    wire logic                pin_used = (els != TCC_ELS_OFF);

    assign mode = cnt.center_aligned_sel ? TCC_MODE_CENTER_PWM :
                  ctrl_q.mode_sel_b      ? TCC_MODE_EDGE_PWM :
                  ctrl_q.mode_sel_a      ? TCC_MODE_COMPARE :
                                           TCC_MODE_CAPTURE;

    wire logic                is_cap = (mode == TCC_MODE_CAPTURE);
    wire logic                is_cmp = (mode == TCC_MODE_COMPARE);
    wire logic                is_epwm = (mode == TCC_MODE_EDGE_PWM);
    wire logic                is_cpwm = (mode == TCC_MODE_CENTER_PWM);

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire logic                ap_take = hsel && htrans[1] && hready;
    wire logic [TCC_ADDR_W-1:0] ap_addr = haddr[TCC_ADDR_W-1:0];
    wire logic                ap_rd = ap_take && !hwrite;
    wire logic                rd_sc = ap_rd && (ap_addr == TCC_ADDR_SC);
    wire logic                rd_hi = ap_rd && (ap_addr == TCC_ADDR_VAL_HI);
    wire logic                rd_lo = ap_rd && (ap_addr == TCC_ADDR_VAL_LO);
    wire logic                wr_sc = dp_wr_q && (dp_addr_q == TCC_ADDR_SC);
    wire logic                wr_hi = dp_wr_q && (dp_addr_q == TCC_ADDR_VAL_HI);
    wire logic                wr_lo = dp_wr_q && (dp_addr_q == TCC_ADDR_VAL_LO);
    wire logic [7:0]          wbyte = hwdata[7:0];

    // ****************************************************************
    // events
    // ****************************************************************
    // edges ignored until the pipeline holds real pin samples
    wire logic                pin_primed = pin_fill_q[2];
    wire logic                rise = pin_primed && pin_s2_q && !pin_prev_q;
    wire logic                fall = pin_primed && !pin_s2_q && pin_prev_q;
    wire logic                cap_edge = is_cap && pin_used &&
                                         ((els[0] && rise) || (els[1] && fall));
    wire logic                match = !is_cap && cnt.count_tick &&
                                      (cnt.main_counter == value_q);
    wire logic                period_start = is_epwm && cnt.count_tick &&
                                             (cnt.main_counter == TCC_CNT_ZERO);
    wire logic                chan_event = cap_edge || match;

    // ****************************************************************
    // read path
    // ****************************************************************
    wire logic [15:0]         rd_view = (rlatched_q && is_cap) ? rbuf_q : value_q;
    wire logic                rd_val = (rd_hi || rd_lo) && is_cap;
    wire logic [7:0]          sc_byte = {ctrl_q.chan_event_flag, ctrl_q.chan_irq_enable,
                                         ctrl_q.mode_sel_b, ctrl_q.mode_sel_a,
                                         ctrl_q.edge_level_sel, 2'b00};
    wire logic [31:0]         rdata_d = rd_sc ? {24'h000000, sc_byte} :
                                        rd_hi ? {24'h000000, rd_view[15:8]} :
                                        rd_lo ? {24'h000000, rd_view[7:0]} :
                                        32'h00000000;

    // ****************************************************************
    // compare write buffer
    // ****************************************************************
    wire logic                buf_wr = !is_cap && (wr_hi || wr_lo);
    wire logic                have_hi = wgot_hi_q || wr_hi;
    wire logic                have_lo = wgot_lo_q || wr_lo;
    wire logic                commit = buf_wr && have_hi && have_lo;
    wire logic [15:0]         commit_val = {wr_hi ? wbyte : whold_hi_q,
                                            wr_lo ? wbyte : whold_lo_q};

    // ****************************************************************
    // flag clear sequence
    // ****************************************************************
    wire logic                clr_req = wr_sc && !wbyte[TCC_BIT_FLAG] && clr_armed_q;
    wire logic                flag_d = chan_event ? 1'b1 :
                                       clr_req ? 1'b0 : ctrl_q.chan_event_flag;

    // ****************************************************************
    // bus slave registers
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dp_wr_q   <= 1'b0;
            dp_addr_q <= '0;
            hrdata_q  <= 32'h00000000;
        end
        else
        begin
            dp_wr_q   <= ap_take && hwrite;
            dp_addr_q <= ap_addr;
            if (ap_rd)
            begin
                hrdata_q <= rdata_d;
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // ****************************************************************
    // control register
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q      <= TCC_CTRL_RST;
            clr_armed_q <= 1'b0;
        end
        else
        begin
            ctrl_q.chan_event_flag <= flag_d;
            if (wr_sc)
            begin
                ctrl_q.chan_irq_enable <= wbyte[TCC_BIT_IE];
                ctrl_q.mode_sel_b      <= wbyte[TCC_BIT_MSB];
                ctrl_q.mode_sel_a      <= wbyte[TCC_BIT_MSA];
                ctrl_q.edge_level_sel  <= wbyte[TCC_BIT_ELS_HI:TCC_BIT_ELS_LO];
            end
            if (chan_event || wr_sc)
            begin
                clr_armed_q <= 1'b0;
            end
            else if (rd_sc && ctrl_q.chan_event_flag)
            begin
                clr_armed_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // interrupt request, registered from next flag and enable
    // ****************************************************************
    wire logic                ie_d = wr_sc ? wbyte[TCC_BIT_IE] : ctrl_q.chan_irq_enable;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= flag_d && ie_d;
        end
    end

    assign chan_irq = irq_q;

    // ****************************************************************
    // channel value, read latch and write holding buffer
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            value_q     <= TCC_VAL_RST;
            rbuf_q      <= TCC_VAL_RST;
            rlatched_q  <= 1'b0;
            rlatch_hi_q <= 1'b0;
            whold_hi_q  <= 8'h00;
            whold_lo_q  <= 8'h00;
            wgot_hi_q   <= 1'b0;
            wgot_lo_q   <= 1'b0;
        end
        else
        begin
            if (cap_edge)
            begin
                value_q <= cnt.main_counter;
            end
            else if (commit)
            begin
                value_q <= commit_val;
            end
            else if (is_cap && wr_hi)
            begin
                value_q[15:8] <= wbyte;
            end
            else if (is_cap && wr_lo)
            begin
                value_q[7:0] <= wbyte;
            end

            if (wr_sc)
            begin
                rlatched_q <= 1'b0;
            end
            else if (rd_val && !rlatched_q)
            begin
                rlatched_q  <= 1'b1;
                rlatch_hi_q <= rd_hi;
                rbuf_q      <= value_q;
            end
            else if (rd_val && (rd_hi != rlatch_hi_q))
            begin
                rlatched_q <= 1'b0;
            end

            if (wr_sc || commit || is_cap)
            begin
                wgot_hi_q <= 1'b0;
                wgot_lo_q <= 1'b0;
            end
            else
            begin
                if (buf_wr && wr_hi)
                begin
                    whold_hi_q <= wbyte;
                    wgot_hi_q  <= 1'b1;
                end
                if (buf_wr && wr_lo)
                begin
                    whold_lo_q <= wbyte;
                    wgot_lo_q  <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // pin input synchroniser
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_s1_q   <= 1'b0;
            pin_s2_q   <= 1'b0;
            pin_prev_q <= 1'b0;
            pin_fill_q <= 3'h0;
        end
        else
        begin
            pin_s1_q   <= pin_in;
            pin_s2_q   <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
            pin_fill_q <= {pin_fill_q[1:0], 1'b1};
        end
    end

    // ****************************************************************
    // pin output
    // ****************************************************************
    logic                     pin_out_d;

    always_comb
    begin
        pin_out_d = pin_out_q;
        unique case (mode)
            TCC_MODE_CAPTURE:
                pin_out_d = pin_out_q;
            TCC_MODE_COMPARE:
                if (match)
                begin
                    unique case (els)
                        TCC_ELS_OFF:    pin_out_d = pin_out_q;
                        TCC_ELS_TOGGLE: pin_out_d = !pin_out_q;
                        TCC_ELS_CLEAR:  pin_out_d = 1'b0;
                        TCC_ELS_SET:    pin_out_d = 1'b1;
                    endcase
                end
            TCC_MODE_EDGE_PWM:
                if (match)
                begin
                    pin_out_d = els[0];
                end
                else if (period_start)
                begin
                    pin_out_d = !els[0];
                end
            TCC_MODE_CENTER_PWM:
                if (match)
                begin
                    pin_out_d = cnt.count_up ? els[0] : !els[0];
                end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_out_q <= 1'b0;
        end
        else
        begin
            pin_out_q <= pin_out_d;
        end
    end

    assign pin_out = pin_out_q;
    assign pin_oe  = pin_used && !is_cap;
endmodule

// File: dv/tcc_channel_sva.sv
// port assertions for the timer channel
`timescale 1ns/1ps
module tcc_channel_sva
    import tcc_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  nrst,
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic                  hready,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic [31:0]           hrdata,
    input wire tcc_pkg::tcc_counter_t cnt,
    input wire logic                  pin_out,
    input wire logic                  pin_oe,
    input wire logic                  chan_irq
);
    wire       rd  = hsel & htrans[1] & hready & !hwrite;
    wire [9:0] a   = haddr[9:0];
    wire       sc  = a == TCC_ADDR_SC;
    wire       map = sc | (a == TCC_ADDR_VAL_HI) | (a == TCC_ADDR_VAL_LO);

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    okay_resp_a: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus answer not okay or not ready");
    rd_hold_a: assert property (!rd |=> $stable(hrdata))
        else $error("read data moved without a read");
    rd_upper_a: assert property (rd |=> hrdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    ctrl_low_a: assert property (rd && sc |=> hrdata[1:0] == 2'b00)
        else $error("unused control bits read nonzero");
    unmapped_rd_a: assert property (rd && !map |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    irq_level_a: assert property (rd && sc |=> (hrdata[7] & hrdata[6]) == $past(chan_irq))
        else $error("interrupt differs from flag and enable");
    pin_oe_a: assert property (rd && sc |=> $past(pin_oe) ==
        (hrdata[3:2] != 2'b00 && (hrdata[5:4] != 2'b00 || $past(cnt.center_aligned_sel))))
        else $error("pin drive enable differs from mode");
    pin_tick_a: assert property ($changed(pin_out) |-> $past(cnt.count_tick))
        else $error("pin changed without a counter tick");

    cover property (rd && sc ##1 hrdata[7]);
    cover property ($rose(chan_irq));
    cover property ($rose(pin_out));
    cover property (cnt.center_aligned_sel && $rose(pin_out));
endmodule

// File: dv/tcc_far.sv
// far side: main counter source and the far end of the timer pin
`timescale 1ns/1ps
module tcc_far
    import tcc_pkg::*;
#(
    parameter logic [15:0] TOP = 16'h01ff
)
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             center,
    input  wire logic             lvl,
    input  wire logic             pin_out,
    input  wire logic             pin_oe,
    output tcc_pkg::tcc_counter_t cnt,
    output logic                  pin_in
);
    logic [15:0] cnt_q;
    logic        tick_q;
    logic        up_q;
    wire         top   = cnt_q == TOP;
    wire         dn    = up_q ? (top && center) : (cnt_q != 16'h0000);
    wire [15:0]  cnt_d = dn ? cnt_q - 16'h0001 : (top ? 16'h0000 : cnt_q + 16'h0001);

    // counter advances every second clock
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
            up_q   <= 1'b1;
        end
        else
        begin
            tick_q <= !tick_q;
            if (!tick_q)
            begin
                cnt_q <= cnt_d;
                up_q  <= !dn;
            end
        end
    end
    assign cnt = '{cnt_q, tick_q, up_q, center};
    // channel wins the wire while it drives
    assign pin_in = pin_oe ? pin_out : lvl;
endmodule

// File: dv/testbench.sv
// self-checking bench for the timer channel
`timescale 1ns/1ps
module testbench;
    import tcc_pkg::*;
    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    logic         hsel = 1'b0;
    logic [31:0]  haddr = 32'h0;
    logic [1:0]   htrans = 2'h0;
    logic         hwrite = 1'b0;
    logic [31:0]  hwdata = 32'h0;
    logic         lvl = 1'b0;
    logic         center = 1'b0;
    logic         hreadyout, hresp, pin_in, pin_out, pin_oe, chan_irq;
    logic [31:0]  hrdata;
    tcc_counter_t cnt;
    int           fails = 0;
    int           checks_done = 0;
    logic [7:0]   r, h1, l1, h2, l2;
    logic [15:0]  c1, c2;
    // control value, pin before match, pin after match, drive enable
    logic [11:0]  rows [8] = '{12'h28a, 12'h38a, 12'h246, 12'h2c6,
                               12'h18a, 12'h1c6, 12'h14a, 12'h100};

    always #10 clk = ~clk;

    tcc_channel DUT (
        .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cnt(cnt),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .chan_irq(chan_irq));
    tcc_far FAR (
        .clk(clk), .nrst(nrst), .center(center), .lvl(lvl), .pin_out(pin_out),
        .pin_oe(pin_oe), .cnt(cnt), .pin_in(pin_in));

    task summarize;
        begin
            $display("checks %0d, mismatches %0d", checks_done, fails);
            if (fails == 0 && checks_done > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input logic [15:0] s, input logic [15:0] e);
        begin
            checks_done++;
            if (s !== e)
            begin
                fails++;
                $display("Error at %0t: seen %h expected %h", $time, s, e);
            end
        end
    endtask
    task expire(input int n);
        begin
            if (n >= 3000)
            begin
                fails++;
                summarize();
            end
        end
    endtask
    task rdy;
        int n;
        begin
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (hreadyout !== 1'b1 && n < 3000);
            expire(n);
        end
    endtask
    // one single transfer, read byte left in r
    task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
        begin
            @(posedge clk);
            hsel <= 1'b1;
            htrans <= 2'h2;
            haddr <= {22'h0, a};
            hwrite <= w;
            rdy();
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= {24'h0, d};
            rdy();
            r = hrdata[7:0];
        end
    endtask
    task wr(input logic [9:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task rc(input logic [9:0] a, input logic [7:0] e);
        begin
            bus(1'b0, a, 8'h00);
            chk({8'h0, r}, {8'h0, e});
        end
    endtask
    task at(input logic [15:0] v);
        int n;
        begin
            n = 0;
            do
            begin
                @(negedge clk);
                n++;
            end
            while (cnt.main_counter !== v && n < 3000);
            expire(n);
        end
    endtask
    // pin edge at a fixed tick phase, counter noted
    task flip(output logic [15:0] c);
        int n;
        begin
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (cnt.count_tick !== 1'b1 && n < 3000);
            expire(n);
            lvl <= !lvl;
            c = cnt.main_counter;
            repeat (8) @(posedge clk);
        end
    endtask
    task rst;
        begin
            nrst <= 1'b0;
            repeat (20) @(posedge clk);
            chk({14'h0, pin_oe, chan_irq}, 16'h0);
            nrst <= 1'b1;
            rc(TCC_ADDR_SC, 8'h00);
            rc(TCC_ADDR_VAL_HI, 8'h00);
            rc(TCC_ADDR_VAL_LO, 8'h00);
        end
    endtask

    initial
    begin
        rst();
        wr(10'h3fc, 8'hff);
        rc(10'h3fc, 8'h00);
        wr(TCC_ADDR_SC, 8'h8f);
        rc(TCC_ADDR_SC, 8'h0c);
        wr(TCC_ADDR_SC, 8'h14);
        wr(TCC_ADDR_VAL_HI, 8'h55);
        wr(TCC_ADDR_SC, 8'h14);
        wr(TCC_ADDR_VAL_LO, 8'h20);
        rc(TCC_ADDR_VAL_LO, 8'h00);
        wr(TCC_ADDR_VAL_HI, 8'h01);
        rc(TCC_ADDR_VAL_HI, 8'h01);
        rc(TCC_ADDR_VAL_LO, 8'h20);
        at(16'h0130);
        chk({15'h0, pin_out}, 16'h1);
        rc(TCC_ADDR_SC, 8'h94);
        chk({15'h0, chan_irq}, 16'h0);
        wr(TCC_ADDR_SC, 8'hd4);
        rc(TCC_ADDR_SC, 8'hd4);
        chk({15'h0, chan_irq}, 16'h1);
        wr(TCC_ADDR_SC, 8'h54);
        rc(TCC_ADDR_SC, 8'h54);
        chk({15'h0, chan_irq}, 16'h0);
        at(16'h0130);
        rc(TCC_ADDR_SC, 8'hd4);
        at(16'h0121);
        wr(TCC_ADDR_SC, 8'h54);
        rc(TCC_ADDR_SC, 8'hd4);
        foreach (rows[i])
        begin
            wr(TCC_ADDR_SC, rows[i][11:4]);
            at(16'h0000);
            at(16'h0010);
            chk({15'h0, pin_out}, {15'h0, rows[i][3]});
            chk({15'h0, pin_oe}, {15'h0, rows[i][1]});
            at(16'h0180);
            chk({15'h0, pin_out}, {15'h0, rows[i][2]});
        end
        // pin has been idle at lvl since the last row
        for (int e = 1; e < 4; e++)
        begin
            wr(TCC_ADDR_SC, {4'h0, e[1:0], 2'h0});
            bus(1'b0, TCC_ADDR_SC, 8'h00);
            wr(TCC_ADDR_SC, {4'h0, e[1:0], 2'h0});
            flip(c1);
            rc(TCC_ADDR_SC, {e[0], 3'h0, e[1:0], 2'h0});
            wr(TCC_ADDR_SC, {4'h0, e[1:0], 2'h0});
            flip(c1);
            rc(TCC_ADDR_SC, {e[1], 3'h0, e[1:0], 2'h0});
        end
        flip(c1);
        bus(1'b0, TCC_ADDR_VAL_HI, 8'h00);
        h1 = r;
        flip(c2);
        bus(1'b0, TCC_ADDR_VAL_LO, 8'h00);
        l1 = r;
        bus(1'b0, TCC_ADDR_VAL_HI, 8'h00);
        h2 = r;
        bus(1'b0, TCC_ADDR_VAL_LO, 8'h00);
        l2 = r;
        chk(({h2, l2} - {h1, l1}) & 16'h01ff, (c2 - c1) & 16'h01ff);
        bus(1'b0, TCC_ADDR_VAL_HI, 8'h00);
        flip(c1);
        wr(TCC_ADDR_SC, 8'h0c);
        bus(1'b0, TCC_ADDR_VAL_LO, 8'h00);
        l1 = r;
        bus(1'b0, TCC_ADDR_VAL_HI, 8'h00);
        h1 = r;
        chk(({h1, l1} - {h2, l2}) & 16'h01ff, (c1 - c2) & 16'h01ff);
        // center-aligned high-true pulse, value written high byte first
        center <= 1'b1;
        wr(TCC_ADDR_SC, 8'h08);
        wr(TCC_ADDR_VAL_HI, 8'h01);
        wr(TCC_ADDR_VAL_LO, 8'h00);
        at(16'h01ff);
        bus(1'b0, TCC_ADDR_SC, 8'h00);
        wr(TCC_ADDR_SC, 8'h08);
        rc(TCC_ADDR_SC, 8'h08);
        chk({15'h0, pin_oe}, 16'h1);
        at(16'h0080);
        chk({15'h0, pin_out}, 16'h1);
        rc(TCC_ADDR_SC, 8'h88);
        at(16'h0180);
        chk({15'h0, pin_out}, 16'h0);
        @(posedge clk);
        center <= 1'b0;
        rst();
        summarize();
    end
endmodule

bind tcc_channel tcc_channel_sva u_sva (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cnt(cnt),
    .pin_out(pin_out), .pin_oe(pin_oe), .chan_irq(chan_irq));
